// [pts_pkg.sv]
// Constants, register map and mode type of the reference pulse tracking supervisor
package pts_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          FW              = 16;
    localparam int          TCW             = 20;
    localparam int          IW              = 24;
    localparam int          OFS_W           = 8;
    localparam int          IRQ_W           = 4;
    localparam int          NV_DEPTH        = 16;
    localparam int          NV_AW           = 4;

    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_STATUS      = 8'h04;
    localparam logic [7:0]  OFS_FREQ_CMD    = 8'h08;
    localparam logic [7:0]  OFS_FREQ_USE    = 8'h0c;
    localparam logic [7:0]  OFS_TC          = 8'h10;
    localparam logic [7:0]  OFS_ALARM_WIN   = 8'h14;
    localparam logic [7:0]  OFS_TRACK_WIN   = 8'h18;
    localparam logic [7:0]  OFS_FREQ_LIM    = 8'h1c;
    localparam logic [7:0]  OFS_PH_OFS      = 8'h20;
    localparam logic [7:0]  OFS_CFG06       = 8'h24;
    localparam logic [7:0]  OFS_INT_STAT    = 8'h28;
    localparam logic [7:0]  OFS_INT_MASK    = 8'h2c;

    localparam int          CTRL_START_BIT  = 0;
    localparam int          CTRL_STOP_BIT   = 1;
    localparam int          CTRL_AUTO_BIT   = 2;
    localparam int          CFG_RESTART_BIT = 2;
    localparam logic [3:0]  NV_FREQ_IDX     = 4'h0;
    localparam logic [3:0]  NV_CFG06_IDX    = 4'h6;

    localparam int          IRQ_ALARM       = 0;
    localparam int          IRQ_TRACK_LOST  = 1;
    localparam int          IRQ_LIMIT_ERR   = 2;
    localparam int          IRQ_CMD_REJECT  = 3;

    localparam logic [15:0] WIN_DEF_NS      = 16'h0fa0;
    localparam logic [15:0] FREQ_LIM_DEF    = 16'h7ffd;
    localparam logic [19:0] TC_AUTO_TARGET_S = 20'h003e8;
    localparam logic [19:0] TC_RESET_S      = 20'h003e8;
    localparam logic [19:0] TC_STEP_S       = 20'h00001;
    localparam logic [7:0]  CFG06_RESET     = 8'h00;
    localparam int          HOLD_AVG_SHIFT  = 4;

    localparam logic [2:0]  STAT_FREE       = 3'h1;
    localparam logic [2:0]  STAT_TRACK      = 3'h3;
    localparam logic [2:0]  STAT_HOLD       = 3'h4;
    localparam logic [2:0]  STAT_STUCK      = 3'h5;

    localparam int          REF_TIMEOUT_MS  = 1500;
    localparam int          CLK_KHZ         = 100000;
    localparam int unsigned REF_TIMEOUT_CYC = REF_TIMEOUT_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        PTS_FREE  = 2'b00,
        PTS_TRACK = 2'b01,
        PTS_HOLD  = 2'b11,
        PTS_STUCK = 2'b10
    } pts_mode_e;
endpackage

// [pts_nv_mem.sv]
// Small parameter store standing in for the nonvolatile memory
`timescale 1ns/10ps
module pts_nv_mem #(
    parameter int DW    = 16,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          clk_in,
    input  wire logic          srst_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [DW-1:0] wr_data_in,
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [DW-1:0] rd_data_out
);
    logic [DW-1:0] mem_r [DEPTH];

    // Cleared by reset so simulation never reads unknown contents
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            rd_data_out <= '0;
        end else begin
            if (wr_en_in) begin
                mem_r[wr_addr_in] <= wr_data_in;
            end
            rd_data_out <= mem_r[rd_addr_in];
        end
    end
endmodule // pts_nv_mem

// [pts_supervisor.sv]
// Reference pulse tracking supervisor with register port and interrupt
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module pts_supervisor #(
    parameter int unsigned REF_TIMEOUT_CYC = pts_pkg::REF_TIMEOUT_CYC
) (
    input  wire logic                       clk_in,
    input  wire logic                       srst_in,
    input  wire logic [pts_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [pts_pkg::DATA_W-1:0] wr_data_in,
    input  wire logic                       wr_in,
    input  wire logic                       rd_in,
    output logic      [pts_pkg::DATA_W-1:0] rd_data_out,
    input  wire logic                       reference_pulse_in,
    input  wire logic signed [15:0]         phase_err_in,
    input  wire logic                       noise_valid_in,
    input  wire logic [pts_pkg::TCW-1:0]    noise_tc_in,
    output logic signed [pts_pkg::FW:0]     freq_word_out,
    output logic signed [pts_pkg::OFS_W-1:0] fine_offset_out,
    output logic [pts_pkg::TCW-1:0]         loop_tc_out,
    output logic                            alarm_out,
    output logic                            tracking_out,
    output logic [2:0]                      status_out,
    output logic                            irq_out
);
    localparam int FW  = pts_pkg::FW;
    localparam int IW  = pts_pkg::IW;
    localparam int TCW = pts_pkg::TCW;

    function automatic logic [4:0] msb_idx(input logic [TCW-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < TCW; i++) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic signed [IW-1:0] clamp(input logic signed [IW-1:0] v,
                                                   input logic [15:0] lim);
        logic signed [IW-1:0] l;
        l = signed'({8'h00, lim});
        if (v > l) begin
            return l;
        end else if (v < -l) begin
            return -l;
        end
        return v;
    endfunction

    pts_pkg::pts_mode_e          mode_r, mode_nxt;
    logic signed [FW-1:0]        center_r;
    logic signed [FW:0]          freq_r, freq_nxt;
    logic signed [FW:0]          hold_r, hold_nxt;
    logic signed [IW-1:0]        integ_r, integ_nxt;
    logic [TCW-1:0]              tc_r, tc_nxt, tc_user_r;
    logic                        auto_r;
    logic [15:0]                 awin_r, twin_r, flim_r;
    logic signed [7:0]           ofs_r;
    logic [7:0]                  cfg06_r;
    logic [pts_pkg::IRQ_W-1:0]   int_stat_r, int_mask_r, events;
    logic                        alarm_r, alarm_nxt, limit_r, limit_nxt;
    logic [31:0]                 tmo_cnt_r;
    logic                        boot_r, boot_ld_r;
    logic [FW-1:0]               nv_rd;
    logic [pts_pkg::DATA_W-1:0]  rd_mux;

    // Bus decode
    wire wr_ctrl  = wr_in && (addr_in == pts_pkg::OFS_CTRL);
    wire wr_fcmd  = wr_in && (addr_in == pts_pkg::OFS_FREQ_CMD);
    wire wr_tc    = wr_in && (addr_in == pts_pkg::OFS_TC);
    wire wr_awin  = wr_in && (addr_in == pts_pkg::OFS_ALARM_WIN);
    wire wr_twin  = wr_in && (addr_in == pts_pkg::OFS_TRACK_WIN);
    wire wr_flim  = wr_in && (addr_in == pts_pkg::OFS_FREQ_LIM);
    wire wr_ofs   = wr_in && (addr_in == pts_pkg::OFS_PH_OFS);
    wire wr_cfg   = wr_in && (addr_in == pts_pkg::OFS_CFG06);
    wire wr_istat = wr_in && (addr_in == pts_pkg::OFS_INT_STAT);
    wire wr_imask = wr_in && (addr_in == pts_pkg::OFS_INT_MASK);
    wire do_stop  = wr_ctrl && wr_data_in[pts_pkg::CTRL_STOP_BIT];
    wire do_start = wr_ctrl && wr_data_in[pts_pkg::CTRL_START_BIT] && !do_stop;
    wire fcmd_ok  = wr_fcmd && (mode_r == pts_pkg::PTS_FREE);
    wire restart  = cfg06_r[pts_pkg::CFG_RESTART_BIT];

    // Phase error with fine offset applied, and window tests
    wire signed [FW:0] err = {phase_err_in[15], phase_err_in} + {{9{ofs_r[7]}}, ofs_r};
    wire [FW:0]   err_abs   = err[FW] ? 17'(-err) : 17'(err);
    wire          alarm_hit = err_abs > {1'b0, awin_r};
    wire          stop_hit  = err_abs > {1'b0, twin_r};
    wire          ref_lost  = (mode_r == pts_pkg::PTS_TRACK) && (tmo_cnt_r >= REF_TIMEOUT_CYC - 1);
    // Narrowing only: a larger value than the default is ignored
    wire [15:0]   lim_eff   = (flim_r < pts_pkg::FREQ_LIM_DEF) ? flim_r : pts_pkg::FREQ_LIM_DEF;
    wire [4:0]    ishift    = msb_idx(tc_r);
    wire [4:0]    pshift    = msb_idx(tc_r) >> 1;
    wire signed [IW-1:0] err_w   = IW'(err);
    wire signed [IW-1:0] integ_s = clamp(integ_r + (err_w >>> ishift), lim_eff);
    wire signed [IW-1:0] corr    = clamp(integ_s + (err_w >>> pshift), lim_eff);
    wire          at_lim    = (corr == signed'({8'h00, lim_eff})) ||
                              (corr == -signed'({8'h00, lim_eff}));
    wire signed [FW:0]   center_x = {center_r[FW-1], center_r};
    wire signed [FW:0]   freq_trk = center_x + corr[FW:0];
    wire signed [FW+1:0] hold_d   = {freq_r[FW], freq_r} - {hold_r[FW], hold_r};
    wire signed [FW+1:0] hold_s   = hold_d >>> pts_pkg::HOLD_AVG_SHIFT;
    wire [FW-1:0] nv_wdata  = wr_cfg ? {8'h00, wr_data_in[7:0]} : wr_data_in[FW-1:0];
    wire [3:0]    nv_waddr  = wr_cfg ? pts_pkg::NV_CFG06_IDX : pts_pkg::NV_FREQ_IDX;

    pts_nv_mem #(
        .DW    (FW),
        .DEPTH (pts_pkg::NV_DEPTH),
        .AW    (pts_pkg::NV_AW)
    ) u_nv (
        .clk_in      (clk_in),
        .srst_in     (srst_in),
        .wr_en_in    (fcmd_ok || wr_cfg),
        .wr_addr_in  (nv_waddr),
        .wr_data_in  (nv_wdata),
        .rd_addr_in  (pts_pkg::NV_FREQ_IDX),
        .rd_data_out (nv_rd)
    );

    // Mode sequencing and loop arithmetic
    always_comb begin
        mode_nxt  = mode_r;
        freq_nxt  = freq_r;
        hold_nxt  = hold_r;
        integ_nxt = integ_r;
        alarm_nxt = alarm_r;
        limit_nxt = limit_r;
        events    = '0;
        if (wr_fcmd && !fcmd_ok) begin
            events[pts_pkg::IRQ_CMD_REJECT] = 1'b1;
        end
        if (do_stop) begin
            mode_nxt  = pts_pkg::PTS_FREE;
            freq_nxt  = center_x;
            alarm_nxt = 1'b0;
            limit_nxt = 1'b0;
        end else if (do_start) begin
            // A fresh start is also the way out of status 5
            mode_nxt  = pts_pkg::PTS_TRACK;
            freq_nxt  = center_x;
            hold_nxt  = center_x;
            integ_nxt = '0;
        end else if (fcmd_ok) begin
            freq_nxt = {wr_data_in[FW-1], wr_data_in[FW-1:0]};
        end else begin
            case (mode_r)
                pts_pkg::PTS_TRACK: begin
                    if (reference_pulse_in) begin
                        alarm_nxt = alarm_hit;
                        if (alarm_hit && !alarm_r) begin
                            events[pts_pkg::IRQ_ALARM] = 1'b1;
                        end
                        if (stop_hit) begin
                            mode_nxt = restart ? pts_pkg::PTS_HOLD : pts_pkg::PTS_STUCK;
                            freq_nxt = hold_r;
                            events[pts_pkg::IRQ_TRACK_LOST] = 1'b1;
                        end else begin
                            integ_nxt = integ_s;
                            freq_nxt  = freq_trk;
                            hold_nxt  = hold_r + hold_s[FW:0];
                            limit_nxt = at_lim;
                            if (at_lim && alarm_hit) begin
                                events[pts_pkg::IRQ_LIMIT_ERR] = 1'b1;
                            end
                        end
                    end else if (ref_lost) begin
                        mode_nxt = restart ? pts_pkg::PTS_HOLD : pts_pkg::PTS_STUCK;
                        freq_nxt = hold_r;
                        events[pts_pkg::IRQ_TRACK_LOST] = 1'b1;
                    end
                end
                pts_pkg::PTS_HOLD: begin
                    if (reference_pulse_in && !stop_hit && restart) begin
                        mode_nxt  = pts_pkg::PTS_TRACK;
                        integ_nxt = '0;
                        alarm_nxt = alarm_hit;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Time constant: forced, from noise data, or crawling toward 1000 s
    always_comb begin
        tc_nxt = tc_r;
        if (!auto_r) begin
            tc_nxt = tc_user_r;
        end else if (reference_pulse_in) begin
            if (noise_valid_in) begin
                tc_nxt = noise_tc_in;
            end else if (tc_r < pts_pkg::TC_AUTO_TARGET_S) begin
                tc_nxt = tc_r + pts_pkg::TC_STEP_S;
            end else if (tc_r > pts_pkg::TC_AUTO_TARGET_S) begin
                tc_nxt = tc_r - pts_pkg::TC_STEP_S;
            end
        end
    end

    // Register read selection; unmapped offsets read zero
    always_comb begin
        if (addr_in == pts_pkg::OFS_CTRL) begin
            rd_mux = {29'h0, auto_r, 2'b00};
        end else if (addr_in == pts_pkg::OFS_STATUS) begin
            rd_mux = {26'h0, limit_r, alarm_r, mode_r == pts_pkg::PTS_TRACK, status_out};
        end else if (addr_in == pts_pkg::OFS_FREQ_CMD) begin
            rd_mux = {{16{center_r[FW-1]}}, center_r};
        end else if (addr_in == pts_pkg::OFS_FREQ_USE) begin
            rd_mux = {{15{freq_r[FW]}}, freq_r};
        end else if (addr_in == pts_pkg::OFS_TC) begin
            rd_mux = {12'h000, tc_r};
        end else if (addr_in == pts_pkg::OFS_ALARM_WIN) begin
            rd_mux = {16'h0000, awin_r};
        end else if (addr_in == pts_pkg::OFS_TRACK_WIN) begin
            rd_mux = {16'h0000, twin_r};
        end else if (addr_in == pts_pkg::OFS_FREQ_LIM) begin
            rd_mux = {16'h0000, flim_r};
        end else if (addr_in == pts_pkg::OFS_PH_OFS) begin
            rd_mux = {{24{ofs_r[7]}}, ofs_r};
        end else if (addr_in == pts_pkg::OFS_CFG06) begin
            rd_mux = {24'h000000, cfg06_r};
        end else if (addr_in == pts_pkg::OFS_INT_STAT) begin
            rd_mux = {28'h0, int_stat_r};
        end else if (addr_in == pts_pkg::OFS_INT_MASK) begin
            rd_mux = {28'h0, int_mask_r};
        end else begin
            rd_mux = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mode_r  <= pts_pkg::PTS_FREE;
            freq_r  <= '0;
            hold_r  <= '0;
            integ_r <= '0;
            alarm_r <= 1'b0;
            limit_r <= 1'b0;
            tc_r    <= pts_pkg::TC_RESET_S;
        end else begin
            mode_r  <= mode_nxt;
            freq_r  <= boot_ld_r ? {nv_rd[FW-1], nv_rd} : freq_nxt;
            hold_r  <= hold_nxt;
            integ_r <= integ_nxt;
            alarm_r <= alarm_nxt;
            limit_r <= limit_nxt;
            tc_r    <= tc_nxt;
        end
    end

    // Software settings and power-on copy of the stored frequency
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            center_r  <= '0;
            tc_user_r <= pts_pkg::TC_RESET_S;
            auto_r    <= 1'b1;
            awin_r    <= pts_pkg::WIN_DEF_NS;
            twin_r    <= pts_pkg::WIN_DEF_NS;
            flim_r    <= pts_pkg::FREQ_LIM_DEF;
            ofs_r     <= '0;
            cfg06_r   <= pts_pkg::CFG06_RESET;
            boot_r    <= 1'b1;
            boot_ld_r <= 1'b0;
        end else begin
            boot_r    <= 1'b0;
            boot_ld_r <= boot_r;
            if (boot_ld_r) begin
                center_r <= signed'(nv_rd);
            end else if (fcmd_ok) begin
                center_r <= signed'(wr_data_in[FW-1:0]);
            end
            if (wr_tc) begin
                tc_user_r <= wr_data_in[TCW-1:0];
                auto_r    <= 1'b0;
            end else if (wr_ctrl) begin
                auto_r <= wr_data_in[pts_pkg::CTRL_AUTO_BIT];
            end
            if (wr_awin) awin_r <= wr_data_in[15:0];
            if (wr_twin) twin_r <= wr_data_in[15:0];
            if (wr_flim) flim_r <= wr_data_in[15:0];
            if (wr_ofs) ofs_r <= signed'(wr_data_in[7:0]);
            if (wr_cfg) cfg06_r <= wr_data_in[7:0];
        end
    end

    // Interrupt status: a new event wins over a same-cycle clear
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            int_stat_r <= '0;
            int_mask_r <= '0;
            tmo_cnt_r  <= '0;
        end else begin
            int_stat_r <= (int_stat_r & ~(wr_istat ? wr_data_in[3:0] : 4'h0)) | events;
            if (wr_imask) int_mask_r <= wr_data_in[3:0];
            tmo_cnt_r <= (reference_pulse_in || mode_nxt != pts_pkg::PTS_TRACK) ? 32'h0
                                                                              : tmo_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_data_out     <= '0;
            freq_word_out   <= '0;
            fine_offset_out <= '0;
            loop_tc_out     <= pts_pkg::TC_RESET_S;
            alarm_out       <= 1'b0;
            tracking_out    <= 1'b0;
            status_out      <= pts_pkg::STAT_FREE;
            irq_out         <= 1'b0;
        end else begin
            rd_data_out     <= rd_in ? rd_mux : '0;
            freq_word_out   <= freq_r;
            fine_offset_out <= ofs_r;
            loop_tc_out     <= tc_r;
            alarm_out       <= alarm_nxt;
            tracking_out    <= mode_nxt == pts_pkg::PTS_TRACK;
            status_out      <= (mode_nxt == pts_pkg::PTS_TRACK) ? pts_pkg::STAT_TRACK :
                               (mode_nxt == pts_pkg::PTS_HOLD)  ? pts_pkg::STAT_HOLD  :
                               (mode_nxt == pts_pkg::PTS_STUCK) ? pts_pkg::STAT_STUCK :
                                                                  pts_pkg::STAT_FREE;
            irq_out         <= |((int_stat_r | events) & int_mask_r);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    wire signed [FW+1:0] dev = {freq_r[FW], freq_r} - {center_x[FW], center_x};
    wire pulse_trk = reference_pulse_in && mode_r == pts_pkg::PTS_TRACK && !wr_ctrl && !wr_fcmd;

    a_fcmd_rejected: assert property (wr_fcmd && mode_r != pts_pkg::PTS_FREE |=> $stable(center_r))
        else $error("frequency command taken outside free run");
    a_fcmd_applied: assert property (fcmd_ok |=> freq_r == {$past(wr_data_in[15]), $past(wr_data_in[15:0])})
        else $error("frequency command not applied at once");
    a_tc_forced: assert property (wr_tc |=> ##2 loop_tc_out == $past(wr_data_in[19:0], 3))
        else $error("forced time constant not used");
    a_alarm_keeps: assert property (pulse_trk && alarm_hit && !stop_hit |=> alarm_out && tracking_out)
        else $error("alarm missing or tracking dropped");
    a_track_stop: assert property (pulse_trk && stop_hit |=> !tracking_out ##1 !tracking_out)
        else $error("tracking kept beyond tracking window");
    a_win_default: assert property ($fell(srst_in) |-> awin_r == 16'h0fa0 && twin_r == 16'h0fa0)
        else $error("window default wrong");
    a_freq_span: assert property (mode_r == pts_pkg::PTS_TRACK |-> dev <= 18'sd32765 && dev >= -18'sd32765)
        else $error("correction outside default span");
    a_limit_err: assert property ($rose(int_stat_r[pts_pkg::IRQ_LIMIT_ERR]) |-> alarm_r)
        else $error("limit error without alarm");
    a_no_restart: assert property (pulse_trk && stop_hit && !restart |=> status_out == 3'h5)
        else $error("status 5 not entered");
    a_stop_free: assert property (do_stop |=> mode_r == pts_pkg::PTS_FREE && freq_r == center_x)
        else $error("stop did not restore stored frequency");

    c_track_to_hold: cover property (mode_r == pts_pkg::PTS_TRACK ##[1:200] mode_r == pts_pkg::PTS_HOLD);
    c_stuck_restart: cover property (mode_r == pts_pkg::PTS_STUCK ##[1:200] mode_r == pts_pkg::PTS_TRACK);
    c_fcmd_taken: cover property (fcmd_ok);
    c_alarm_irq: cover property ($rose(irq_out) && alarm_r);
endmodule // pts_supervisor

// [pts_ref_src.sv]
// Reference pulse source model with its phase error
`timescale 1ns/10ps
module pts_ref_src (
    input  wire logic               clk_in,
    input  wire logic               fire_in,
    input  wire logic signed [15:0] err_in,
    output logic                    pulse_out,
    output logic signed [15:0]      err_out
);
    initial begin
        pulse_out = 1'b0;
        err_out   = 16'sh0;
    end
    // Error means nothing off the pulse, so it is scrambled there
    always @(posedge clk_in) begin
        pulse_out <= fire_in;
        err_out   <= fire_in ? err_in : ~err_out;
    end
endmodule // pts_ref_src

// [pts_supervisor_bench.sv]
// Self-checking bench of the reference pulse tracking supervisor
`timescale 1ns/10ps
module pts_supervisor_bench;
    logic clk_in = 0, srst_in = 1, wr_in = 0, rd_in = 0, fire = 0, nv = 0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wr_data_in = 32'h0, rdv, v;
    logic signed [15:0] err_v = 16'sh0, err_w;
    logic [19:0] ntc = 20'h0;
    logic pulse, alarm, trk, irq;
    logic [2:0] st;
    logic [31:0] rdo;
    logic signed [16:0] fw;
    logic signed [7:0] fo;
    logic [19:0] tc;
    int fail_count = 0, cmp_count = 0, cyc = 0, seed = 12;
    always #5 clk_in = ~clk_in;
    pts_ref_src ref_src (.clk_in(clk_in), .fire_in(fire), .err_in(err_v), .pulse_out(pulse),
        .err_out(err_w));
    pts_supervisor #(.REF_TIMEOUT_CYC(200)) dut (.clk_in(clk_in), .srst_in(srst_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
        .rd_data_out(rdo), .reference_pulse_in(pulse), .phase_err_in(err_w),
        .noise_valid_in(nv), .noise_tc_in(ntc), .freq_word_out(fw), .fine_offset_out(fo),
        .loop_tc_out(tc), .alarm_out(alarm), .tracking_out(trk), .status_out(st),
        .irq_out(irq));
    function automatic logic [31:0] sx16(input logic [15:0] x);
        return {{16{x[15]}}, x};
    endfunction
    // One automatic step toward the target per pulse when no noise data is offered
    function automatic logic [19:0] tc_step(input logic [19:0] t);
        if (t < pts_pkg::TC_AUTO_TARGET_S) return t + pts_pkg::TC_STEP_S;
        if (t > pts_pkg::TC_AUTO_TARGET_S) return t - pts_pkg::TC_STEP_S;
        return t;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (e !== g) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a; wr_data_in <= d; wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        addr_in <= a; rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rdv = rdo;
    endtask
    task automatic fire_pulse(input logic signed [15:0] e);
        @(posedge clk_in);
        fire <= 1'b1; err_v <= e;
        @(posedge clk_in);
        fire <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task automatic complete_run;
        if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Ceiling is far above the few hundred cycles the sequence needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        ntc <= 20'($random(seed));
        #1 chk("loop_tc", {12'h0, pts_pkg::TC_RESET_S}, {12'h0, tc});
        rd(pts_pkg::OFS_ALARM_WIN); chk("alarm_win", 32'h0fa0, rdv);
        rd(pts_pkg::OFS_TRACK_WIN); chk("track_win", 32'h0fa0, rdv);
        rd(pts_pkg::OFS_FREQ_LIM); chk("freq_lim", 32'h7ffd, rdv);
        rd(pts_pkg::OFS_CFG06); chk("cfg06", 32'h0, rdv);
        rd(8'h40); chk("unmapped", 32'h0, rdv);
        v = $random(seed);
        wr(pts_pkg::OFS_FREQ_CMD, {16'h0, v[15:0]});
        @(posedge clk_in);
        #1 chk("freq_use", sx16(v[15:0]), {{15{fw[16]}}, fw});
        rd(pts_pkg::OFS_FREQ_CMD); chk("freq_store", sx16(v[15:0]), rdv);
        wr(pts_pkg::OFS_PH_OFS, {24'h0, v[23:16]});
        rd(pts_pkg::OFS_PH_OFS); chk("fine_ofs", {{24{v[23]}}, v[23:16]}, rdv);
        chk("fine_out", {{24{v[23]}}, v[23:16]}, {{24{fo[7]}}, fo});
        wr(pts_pkg::OFS_TC, {12'h0, v[19:0]});
        rd(pts_pkg::OFS_TC); chk("tc_force", {12'h0, v[19:0]}, rdv);
        wr(pts_pkg::OFS_INT_MASK, 32'h2);
        wr(pts_pkg::OFS_CTRL, 32'h1);
        wr(pts_pkg::OFS_FREQ_CMD, 32'h1234);
        rd(pts_pkg::OFS_INT_STAT); chk("cmd_reject", 32'h8, rdv & 32'h8);
        chk("status_trk", 32'h3, {29'h0, st});
        fire_pulse(16'sd3000); chk("alarm_low", 32'h0, {31'h0, alarm});
        wr(pts_pkg::OFS_ALARM_WIN, 32'd100);
        fire_pulse(16'sd300); chk("alarm_up", 32'h3, {30'h0, alarm, trk});
        fire_pulse(16'sd5000); chk("trip", 32'h5, {28'h0, trk, st});
        @(posedge clk_in);
        #1 chk("irq_set", 32'h1, {31'h0, irq});
        wr(pts_pkg::OFS_INT_STAT, 32'hf);
        @(posedge clk_in);
        #1 chk("irq_clr", 32'h0, {31'h0, irq});
        wr(pts_pkg::OFS_CTRL, 32'h1);
        #1 chk("restart", 32'h3, {29'h0, st});
        wr(pts_pkg::OFS_CTRL, 32'h6);
        @(posedge clk_in);
        #1 chk("stop", {st, fw}, {3'h1, v[15], v[15:0]});
        fire_pulse(16'sd0); chk("tc_step", {12'h0, tc_step(v[19:0])}, {12'h0, tc});
        @(posedge clk_in);
        nv <= 1'b1;
        fire_pulse(16'sd0); chk("tc_noise", {12'h0, ntc}, {12'h0, tc});
        wr(pts_pkg::OFS_CFG06, 32'h4);
        wr(pts_pkg::OFS_CTRL, 32'h1);
        // Reference goes missing long enough for the timeout to expire
        repeat (210) @(posedge clk_in);
        #1 chk("holdover", 32'h4, {29'h0, st});
        fire_pulse(16'sd0); chk("resume", 32'h3, {29'h0, st});
        complete_run();
    end
endmodule // pts_supervisor_bench
